// ---- bench/mcu_bus_model.sv ----
// Behavioural model of the processor bus facing the power manager.
`timescale 1ns/1ps
`default_nettype none
module mcu_bus_model
    import pwr_mgr_pkg::*;
(
    input wire logic clk,
    input wire logic active,
    output bus_t bus
);
    integer seed = 32'h7B3C9016;
    initial bus = '0;
    // The strobe toggles while the processor runs and stands low while it sleeps; the
    // other lines keep changing, as noise from other bus users would.
    always @(posedge clk) begin
        bus.ale <= active ? ~bus.ale : 1'b0;
        bus.addr <= 16'($random(seed));
        bus.data <= 8'($random(seed));
        bus.cntl <= 3'($random(seed));
    end
endmodule
`default_nettype wire

// ---- bench/pld_memory_power_manager_tb_top.sv ----
// Self-checking testbench for the power manager.
`timescale 1ns/1ps
`default_nettype none
module pld_memory_power_manager_tb_top;
    import pwr_mgr_pkg::*;
    localparam int IDLE = 4;
    logic clk = 1'b0, reset = 1'b1, warm_reset = 1'b0, reg_wr = 1'b0, cfg_loaded = 1'b0;
    logic chip_sel_n = 1'b0, active = 1'b0, mem_select, power_down, io_in, a_oe, p_oe, stby;
    logic [7:0] wdata = 8'h00, re_m = 8'h00, pr_m = 8'h00, d_in = 8'h00, pmr1, pmr2, vmap;
    logic m_act, a_act, ace, mce, aov;
    logic [7:0] mq, mq_exp = 8'h00;
    reg_sel_t reg_sel = REG_NONE;
    bus_t pbus, mcu_bus, array_bus;
    integer fail_count = 0, total_checks = 0, seed = 32'h7B3C9016, i;
    int m_reg[4] = '{0, 0, 0, 0};
    int mask[4] = '{0, PMR1_WMASK, PMR2_WMASK, MAP_WMASK};
    initial forever #2 clk = ~clk;
    // Write data rides on the processor data lines during a register write.
    assign mcu_bus = reg_wr ? {pbus.addr, wdata, pbus.ale, pbus.cntl} : pbus;
    mcu_bus_model PEER (.clk(clk), .active(active), .bus(pbus));
    pwr_mgr #(.AUTO_PD_IDLE(IDLE)) DUT (.clk(clk), .reset(reset), .warm_reset(warm_reset),
        .mcu_bus(mcu_bus), .reg_wr(reg_wr), .reg_sel(reg_sel), .mcell_re_mask(re_m),
        .mcell_pr_mask(pr_m), .mcell_d(d_in), .cfg_loaded(cfg_loaded),
        .chip_sel_n(chip_sel_n), .array_bus(array_bus), .mem_bus(), .mem_select(mem_select),
        .mem_active(m_act), .array_active(a_act), .array_standby(stby), .array_clk_en(ace),
        .mcell_clk_en(mce), .power_down(power_down), .power_mode_reg_first(pmr1),
        .power_mode_reg_second(pmr2), .memory_mapping_register(vmap), .mcell_q(mq),
        .mcu_io_input_mode(io_in), .addr_out_oe(a_oe), .periph_oe(p_oe),
        .array_out_valid(aov));
    // Macrocell inputs change every cycle.
    always @(posedge clk) begin
        d_in <= 8'($random(seed));
        re_m <= 8'($random(seed));
        pr_m <= 8'($random(seed));
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic write(input reg_sel_t sel, input logic [7:0] val);
        @(posedge clk);
        reg_sel <= sel;
        wdata <= val;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (sel != REG_NONE) m_reg[sel] = val & mask[sel];
        @(posedge clk);
        #1 check({pmr1, pmr2, vmap}, {m_reg[1][7:0], m_reg[2][7:0], m_reg[3][7:0]});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog against a hung run.
    initial begin
        #12000;
        fail_count++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        #1 check({pmr1, pmr2, vmap, io_in, a_oe, p_oe, power_down}, 32'h08);
        check({aov, mq}, 0);
        @(posedge clk);
        reset <= 1'b0;
        cfg_loaded <= 1'b1;
        active <= 1'b1;
        @(posedge clk);
        cfg_loaded <= 1'b0;
        for (i = 0; i < 16; i++) write(reg_sel_t'(i % 4), 8'($random(seed)));
        @(posedge clk);
        chip_sel_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(mem_select, 0);
        check({m_act, aov}, 2'b01);
        @(posedge clk);
        chip_sel_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(mem_select, 1);
        check(m_act, 1);
        write(REG_PMR1, 8'h02);
        active <= 1'b0;
        for (i = 0; i < IDLE + 20 && power_down !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        #1 check(power_down, 1);
        check({array_bus.addr, array_bus.data, mem_select, p_oe}, 0);
        check(m_act, 0);
        @(posedge clk);
        active <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(power_down, 0);
        write(REG_PMR1, 8'h08);
        active <= 1'b0;
        repeat (IDLE + 20) @(posedge clk);
        #1 check({power_down, stby}, 0);
        // Every array input blocked in power-down, so the arrays must fall to standby.
        write(REG_PMR2, 8'h1C);
        write(REG_PMR1, 8'h3A);
        repeat (IDLE + 40) @(posedge clk);
        #1 check({power_down, stby, a_act, ace, mce}, 5'b11000);
        active <= 1'b1;
        write(REG_MAP, 8'hFF);
        @(posedge clk);
        warm_reset <= 1'b1;
        #1 mq_exp = (mq & ~re_m) | pr_m;
        @(posedge clk);
        warm_reset <= 1'b0;
        m_reg[3] = MAP_DEFAULT;
        #1 check({pmr1, vmap, io_in, a_oe, p_oe}, {m_reg[1][7:0], MAP_DEFAULT, 3'b100});
        check(mq, mq_exp);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1 check({pmr1, pmr2}, 0);
        check({mq, aov}, 0);
        tally_and_finish();
    end
endmodule
bind pwr_mgr pwr_mgr_asserts #(.AUTO_PD_IDLE(AUTO_PD_IDLE)) u_chk (.clk(clk), .reset(reset),
    .warm_reset(warm_reset), .mcu_bus(mcu_bus), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .chip_sel_n(chip_sel_n), .array_bus(array_bus), .mem_select(mem_select),
    .power_down(power_down), .power_mode_reg_first(power_mode_reg_first),
    .power_mode_reg_second(power_mode_reg_second), .periph_oe(periph_oe),
    .memory_mapping_register(memory_mapping_register),
    .mcu_io_input_mode(mcu_io_input_mode), .addr_out_oe(addr_out_oe));
`default_nettype wire

// ---- bench/pwr_mgr_asserts.sv ----
// Port-level assertions for the power manager.
`timescale 1ns/1ps
`default_nettype none
module pwr_mgr_asserts
    import pwr_mgr_pkg::*;
#(
    parameter int AUTO_PD_IDLE = AUTO_PD_IDLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic warm_reset,
    input wire bus_t mcu_bus,
    input wire logic reg_wr,
    input wire reg_sel_t reg_sel,
    input wire logic chip_sel_n,
    input wire bus_t array_bus,
    input wire logic mem_select,
    input wire logic power_down,
    input wire logic [7:0] power_mode_reg_first,
    input wire logic [7:0] power_mode_reg_second,
    input wire logic [7:0] memory_mapping_register,
    input wire logic mcu_io_input_mode,
    input wire logic addr_out_oe,
    input wire logic periph_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic ale_r;
    logic [11:0] quiet_r;
    // Counts the cycles for which the address strobe has not changed.
    always_ff @(posedge clk) begin
        ale_r <= mcu_bus.ale;
        quiet_r <= (reset || mcu_bus.ale != ale_r) ? 12'h000 : quiet_r + 12'h001;
    end
    a_pd_needs_enable:
        assert property ($rose(power_down) |-> $past(power_mode_reg_first[PMR1_AUTO_PD_EN_BIT]))
        else $error("power-down entered while disabled");
    a_pd_needs_quiet:
        assert property ($rose(power_down) |-> quiet_r >= 12'(AUTO_PD_IDLE))
        else $error("power-down entered before the strobe idle period");
    a_pd_wakes_up:
        assert property (power_down && mcu_bus.ale != ale_r |-> ##[1:2] !power_down)
        else $error("strobe activity did not end power-down");
    a_pd_blocks_bus:
        assert property ($past(power_down) && power_down |->
            array_bus.addr == 16'h0000 && array_bus.data == 8'h00 && !mem_select)
        else $error("bus not blocked in power-down");
    a_pd_periph_off:
        assert property ($past(power_down) && power_down |-> !periph_oe)
        else $error("peripheral pins driven in power-down");
    a_cs_parks_mem:
        assert property ($past(chip_sel_n) && chip_sel_n |-> !mem_select)
        else $error("memories selected while chip select is off");
    a_first_reg_write:
        assert property (reg_wr && reg_sel == REG_PMR1 |=>
            power_mode_reg_first == ($past(mcu_bus.data) & PMR1_WMASK))
        else $error("first power register write wrong");
    a_second_reg_write:
        assert property (reg_wr && reg_sel == REG_PMR2 |=>
            power_mode_reg_second == ($past(mcu_bus.data) & PMR2_WMASK))
        else $error("second power register write wrong");
    a_power_regs_hold:
        assert property (!reg_wr && !reset |=> $stable(power_mode_reg_first)
            && $stable(power_mode_reg_second))
        else $error("power register changed without a write");
    a_warm_reset_state:
        assert property (warm_reset && !reg_wr |=> memory_mapping_register == MAP_DEFAULT
            && mcu_io_input_mode && !addr_out_oe && !periph_oe)
        else $error("warm reset state wrong");
endmodule
`default_nettype wire

// ---- core/activity_timer.sv ----
// Idle timer that reports when a watched input has been quiet for a count of cycles.
`timescale 1ns/1ps
`default_nettype none
module activity_timer
    import pwr_mgr_pkg::*;
#(
    parameter logic [CNT_W-1:0] LIMIT = 12'h010
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic active,
    output logic idle
);
    logic [CNT_W-1:0] count_r;

    // ------------------------------------------------------------
    // Quiet counter
    // ------------------------------------------------------------
    // Activity restarts the count; idle is raised after LIMIT+1 quiet cycles.
    always_ff @(posedge clk) begin
        if (reset || active) begin
            count_r <= '0;
            idle <= 1'b0;
        end else begin
            if (count_r != LIMIT) begin
                count_r <= count_r + 12'h001;
            end
            idle <= (count_r == LIMIT);
        end
    end
endmodule
`default_nettype wire

// ---- core/pwr_mgr.sv ----
// Power manager for the memory and logic-array module: auto power-down and blocking.
`timescale 1ns/1ps
`default_nettype none
module pwr_mgr
    import pwr_mgr_pkg::*;
#(
    parameter int AUTO_PD_IDLE = AUTO_PD_IDLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic warm_reset,
    input wire bus_t mcu_bus,
    input wire logic reg_wr,
    input wire reg_sel_t reg_sel,
    input wire logic [7:0] mcell_re_mask,
    input wire logic [7:0] mcell_pr_mask,
    input wire logic [7:0] mcell_d,
    input wire logic cfg_loaded,
    input wire logic chip_sel_n,
    output bus_t array_bus,
    output bus_t mem_bus,
    output logic mem_select,
    output logic mem_active,
    output logic array_active,
    output logic array_standby,
    output logic array_clk_en,
    output logic mcell_clk_en,
    output logic power_down,
    output logic [7:0] power_mode_reg_first,
    output logic [7:0] power_mode_reg_second,
    output logic [7:0] memory_mapping_register,
    output logic [7:0] mcell_q,
    output logic mcu_io_input_mode,
    output logic addr_out_oe,
    output logic periph_oe,
    output logic array_out_valid
);
    pwr_state_t state_r;
    pwr_state_t state_nxt;
    bus_t bus_prev_r;
    bus_t gated_bus;
    logic [7:0] pmr1_nxt;
    logic [7:0] pmr2_nxt;
    logic [7:0] map_nxt;
    logic ale_idle;
    logic array_idle;
    logic bus_change;
    logic array_change;
    logic mem_change;
    logic cfg_done_r;
    logic [7:0] mcell_nxt;

    // Writable bits only, so unused bits read as zero.
    function automatic logic [7:0] masked_write(input logic [7:0] d, input logic [7:0] m);
        return d & m;
    endfunction

    // ------------------------------------------------------------
    // Power-down state machine
    // ------------------------------------------------------------
    // Strobe watcher restarts on every strobe edge.
    activity_timer #(
        .LIMIT(CNT_W'(AUTO_PD_IDLE))
    ) u_ale_timer (
        .clk(clk),
        .reset(reset),
        .active(mcu_bus.ale != bus_prev_r.ale),
        .idle(ale_idle)
    );

    // Enter on strobe silence with enable set; strobe activity wakes it.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PWR_RUN: begin
                if (ale_idle && power_mode_reg_first[PMR1_AUTO_PD_EN_BIT]) begin
                    state_nxt = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (mcu_bus.ale != bus_prev_r.ale) begin
                    state_nxt = PWR_RUN;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Signal blocking
    // ------------------------------------------------------------
    // Blocked inputs are held at zero so they cannot toggle.
    assign gated_bus.addr = (state_r == PWR_DOWN) ? 16'h0000 : mcu_bus.addr;
    assign gated_bus.data = (state_r == PWR_DOWN) ? 8'h00 : mcu_bus.data;
    assign gated_bus.ale = (state_r == PWR_DOWN || power_mode_reg_second[PMR2_ALE_BIT])
        ? 1'b0 : mcu_bus.ale;
    assign gated_bus.cntl[2] = power_mode_reg_second[PMR2_CNTL2_BIT] ? 1'b0 : mcu_bus.cntl[2];
    assign gated_bus.cntl[1] = power_mode_reg_second[PMR2_CNTL1_BIT] ? 1'b0 : mcu_bus.cntl[1];
    assign gated_bus.cntl[0] = power_mode_reg_second[PMR2_CNTL0_BIT] ? 1'b0 : mcu_bus.cntl[0];

    // Activity detection: bus_change on the raw processor bus, the other two on what each target really sees.
    assign bus_change = (mcu_bus != bus_prev_r);
    assign array_change = (gated_bus != array_bus);
    assign mem_change = (gated_bus != mem_bus) && (state_r == PWR_RUN) && !chip_sel_n;

    // Array standby after quiet inputs only when turbo is off.
    activity_timer #(
        .LIMIT(CNT_W'(TURBO_IDLE_CYC))
    ) u_array_timer (
        .clk(clk),
        .reset(reset),
        .active(array_change),
        .idle(array_idle)
    );

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    // Power registers clear only on power-on reset; writes work in any mode.
    assign pmr1_nxt = (reg_wr && reg_sel == REG_PMR1)
        ? masked_write(mcu_bus.data, PMR1_WMASK) : power_mode_reg_first;
    assign pmr2_nxt = (reg_wr && reg_sel == REG_PMR2)
        ? masked_write(mcu_bus.data, PMR2_WMASK) : power_mode_reg_second;
    assign map_nxt = (reg_wr && reg_sel == REG_MAP)
        ? masked_write(mcu_bus.data, MAP_WMASK) : memory_mapping_register;
    // Macrocells follow reset and preset equations on warm reset.
    assign mcell_nxt = warm_reset ? ((mcell_q & ~mcell_re_mask) | mcell_pr_mask)
        : (array_clk_en ? mcell_d : mcell_q);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= PWR_RUN;
            bus_prev_r <= '0;
            power_mode_reg_first <= PMR_RESET;
            power_mode_reg_second <= PMR_RESET;
            memory_mapping_register <= MAP_DEFAULT;
            mcell_q <= 8'h00;
            cfg_done_r <= 1'b0;
        end else begin
            state_r <= warm_reset ? PWR_RUN : state_nxt;
            bus_prev_r <= mcu_bus;
            power_mode_reg_first <= pmr1_nxt;
            power_mode_reg_second <= pmr2_nxt;
            memory_mapping_register <= warm_reset ? MAP_DEFAULT : map_nxt;
            mcell_q <= mcell_nxt;
            cfg_done_r <= cfg_done_r | cfg_loaded;
        end
    end

    // Registered outputs toward arrays, memories and ports.
    always_ff @(posedge clk) begin
        if (reset) begin
            array_bus <= '0;
            mem_bus <= '0;
            mem_select <= 1'b0;
            mem_active <= 1'b0;
            array_active <= 1'b0;
            array_standby <= 1'b0;
            array_clk_en <= 1'b0;
            mcell_clk_en <= 1'b0;
            power_down <= 1'b0;
            mcu_io_input_mode <= 1'b1;
            addr_out_oe <= 1'b0;
            periph_oe <= 1'b0;
            array_out_valid <= 1'b0;
        end else begin
            array_bus <= gated_bus;
            if (mem_change) begin
                mem_bus <= gated_bus;
            end
            mem_select <= (state_nxt == PWR_RUN) && !chip_sel_n;
            mem_active <= mem_change;
            array_active <= array_change || bus_change && state_r == PWR_RUN;
            array_standby <= power_mode_reg_first[PMR1_TURBO_OFF_BIT] && array_idle;
            array_clk_en <= !power_mode_reg_first[PMR1_ARRAY_CLK_BIT];
            mcell_clk_en <= !power_mode_reg_first[PMR1_MCELL_CLK_BIT];
            power_down <= !warm_reset && (state_nxt == PWR_DOWN); // Tracks the forced run state.
            mcu_io_input_mode <= warm_reset ? 1'b1 : mcu_io_input_mode;
            addr_out_oe <= !warm_reset && state_nxt == PWR_RUN;
            periph_oe <= !warm_reset && state_nxt == PWR_RUN;
            array_out_valid <= cfg_done_r | cfg_loaded;
        end
    end
endmodule
`default_nettype wire

// ---- include/pwr_mgr_pkg.sv ----
// Package of constants and carrier types for the memory and logic-array power manager.
package pwr_mgr_pkg;

    // ------------------------------------------------------------
    // Register fields and reset values
    // ------------------------------------------------------------
    localparam int PMR1_MCELL_CLK_BIT = 5;
    localparam int PMR1_ARRAY_CLK_BIT = 4;
    localparam int PMR1_TURBO_OFF_BIT = 3;
    localparam int PMR1_AUTO_PD_EN_BIT = 1;
    localparam int PMR2_ALE_BIT = 5;
    localparam int PMR2_CNTL2_BIT = 4;
    localparam int PMR2_CNTL1_BIT = 3;
    localparam int PMR2_CNTL0_BIT = 2;
    localparam logic [7:0] PMR_RESET = 8'h00;
    localparam logic [7:0] PMR1_WMASK = 8'h3A;
    localparam logic [7:0] PMR2_WMASK = 8'h3C;
    localparam int MAP_SR_CODE_BIT = 0;
    localparam int MAP_PERIPH_BIT = 7;
    localparam logic [7:0] MAP_DEFAULT = 8'h00;
    localparam logic [7:0] MAP_WMASK = 8'h9F;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TURBO_IDLE_NS = 70;
    localparam int TURBO_IDLE_CYC = (TURBO_IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AUTO_PD_IDLE_CYC = 64;
    localparam int CNT_W = 12;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic ale;
        logic [2:0] cntl;
    } bus_t;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_PMR1,
        REG_PMR2,
        REG_MAP
    } reg_sel_t;

    typedef enum {
        PWR_RUN,
        PWR_DOWN
    } pwr_state_t;

endpackage
